// ===== rtl/scgate_pkg.sv
// Purpose: Shared constants and types for the stop mode clock gating block.
// Assumes: One 50 MHz clock, synchronous active-high reset.
// Notes: Frame interval and modulo tick period are configuration inputs.
`default_nettype none
package scgate_pkg;

  // Stop mode selection written by configuration.
  typedef enum logic [1:0] {
    SCG_SEL_FAST = 2'h0,
    SCG_SEL_SLOW = 2'h1,
    SCG_SEL_NONE = 2'h2
  } scgate_sel_t;

  // Operating state of the clock controller.
  typedef enum logic [1:0] {
    SCG_RUN,
    SCG_STOP_FAST,
    SCG_STOP_SLOW,
    SCG_STOP_NONE
  } scgate_state_t;

  // Wake-up sources grouped together.
  typedef struct packed {
    logic any_irq;
    logic ext_irq;
    logic host_access;
  } scgate_wake_t;

  // Slow clock divides the main clock by this ratio.
  localparam int unsigned SCG_SLOW_DIV = 256;
  localparam int SCG_DIV_W = 8;
  localparam logic [SCG_DIV_W-1:0] SCG_DIV_LAST = 8'hFF;
  localparam logic [SCG_DIV_W-1:0] SCG_DIV_ZERO = 8'h00;

  // Frame and tick counter widths.
  localparam int SCG_FRM_W = 16;
  localparam logic [SCG_FRM_W-1:0] SCG_FRM_ZERO = 16'h0000;
  localparam logic [SCG_FRM_W-1:0] SCG_FRM_ONE = 16'h0001;

  // Control bit positions in the frame and converter control words.
  localparam int SCG_FRAME_CTRL_STATUS_REG_PHASE_BIT = 5;
  localparam int SCG_CONV_MANUAL_BIT = 0;
  localparam int SCG_CTRL_W = 8;

endpackage : scgate_pkg
`default_nettype wire

// ===== rtl/scgate_div.sv
// Purpose: Divide-by-256 enable pulse generator for slow clock operation.
// Assumes: Runs on the main clock; enable counting only while running.
// Notes: Pulse is one cycle wide every 256 enabled cycles.
`timescale 1ns/1ps
`default_nettype none
module scgate_div (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  output logic tick_out
);
  import scgate_pkg::*;

  logic [SCG_DIV_W-1:0] cnt_ff;

  // Counts enabled cycles and pulses on the last count.
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      cnt_ff <= SCG_DIV_ZERO;
      tick_out <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      tick_out <= (cnt_ff == SCG_DIV_LAST);
    end
  end
endmodule // scgate_div
`default_nettype wire

// ===== rtl/scgate_top.sv
// Purpose: Stop mode clock gating, wake-up, frame timer and modulo timer.
// Assumes: Clock enables model gated clocks; wake pins are asynchronous.
// Assumes: Stop instruction and mode write come from logic on this clock.
// Notes: Enables are registered, so every output lags the state by a cycle.
// Notes: A wake level still high at the next stop ends that stop at once.
// Operation
// - Slow stop halts the processor and runs peripherals at clock/256.
// - In slow stop any interrupt restores full speed everywhere.
// - No-clock stop halts the processor and all peripherals.
// - Only an external interrupt or host access wakes no-clock stop.
// - The frame timer counts correctly at fast and slow rates.
// - Start-of-frame pulses once per frame interval, also when slow.
// - Manual conversion with analog-then-digital phase blocks the pulse.
// - The modulo tick timer follows the peripheral rate, so it slows.
// - Fast stop halts only the processor; any interrupt resumes it.
// - Stop modes are entered only on the stop instruction.
`timescale 1ns/1ps
`default_nettype none
module scgate_top (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic STOP_INSTR_IN,
  input wire scgate_pkg::scgate_sel_t MODE_SEL_IN,
  input wire logic MODE_SEL_WR_IN,
  input wire logic IRQ_IN,
  input wire logic EXT_IRQ_IN,
  input wire logic HOST_ACCESS_IN,
  input wire logic [scgate_pkg::SCG_FRM_W-1:0] FRAME_INTERVAL_IN,
  input wire logic [scgate_pkg::SCG_CTRL_W-1:0] FRAME_CTRL_IN,
  input wire logic [scgate_pkg::SCG_CTRL_W-1:0] CONV_CTRL_IN,
  input wire logic [scgate_pkg::SCG_FRM_W-1:0] TICK_PERIOD_IN,
  output logic CPU_CLK_EN_OUT,
  output logic PERIPH_CLK_EN_OUT,
  output logic SLOW_ACTIVE_OUT,
  output scgate_pkg::scgate_state_t STATE_OUT,
  output scgate_pkg::scgate_sel_t MODE_SEL_OUT,
  output logic FRAME_START_OUT,
  output logic TICK_OUT
);
  import scgate_pkg::*;

  // Synchroniser stages and the decoded wake sources behind them.
  logic [2:0] wake_s1_ff;
  logic [2:0] wake_s2_ff;
  scgate_wake_t wake;

  // Controller state and the held stop mode selection.
  scgate_state_t state_ff;
  scgate_state_t nxt_state;
  scgate_sel_t sel_ff;

  // Rate enables and the two timer counters that run on them.
  logic slow_tick;
  logic periph_en;
  logic [SCG_FRM_W-1:0] frame_cnt_ff;
  logic [SCG_FRM_W-1:0] tick_cnt_ff;
  logic frame_inhibit;

  // True when one more count reaches the limit, so a limit of zero or one
  // pulses on every enabled cycle; both timers share this end test.
  function automatic logic cnt_wraps(
    input logic [SCG_FRM_W-1:0] cnt,
    input logic [SCG_FRM_W-1:0] limit
  );
    cnt_wraps = (cnt + SCG_FRM_ONE >= limit);
  endfunction

  // Wake test shared by both clocked stop modes; an external interrupt is
  // an interrupt too, so it also ends fast and slow stop.
  function automatic logic irq_wake(input scgate_wake_t w);
    irq_wake = w.any_irq || w.ext_irq;
  endfunction

  // Two-stage synchronisers for the asynchronous wake sources; only the
  // second stage is read, so a metastable first stage never reaches logic.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      wake_s1_ff <= 3'h0;
      wake_s2_ff <= 3'h0;
    end else begin
      wake_s1_ff <= {IRQ_IN, EXT_IRQ_IN, HOST_ACCESS_IN};
      wake_s2_ff <= wake_s1_ff;
    end
  end

  assign wake = scgate_wake_t'(wake_s2_ff);

  // Mode selection held until rewritten, untouched by stop entry or exit.
  // Code three names no mode and is dropped, leaving the old setting.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sel_ff <= SCG_SEL_FAST;
    end else if (MODE_SEL_WR_IN && MODE_SEL_IN != 2'h3) begin
      sel_ff <= MODE_SEL_IN;
    end
  end

  // Next operating state from stop instruction and wake sources.
  // A stop instruction outside run state is ignored.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      // Wake levels are ignored while running.
      SCG_RUN: begin
        if (STOP_INSTR_IN) begin
          unique case (sel_ff)
            SCG_SEL_SLOW: nxt_state = SCG_STOP_SLOW;
            SCG_SEL_NONE: nxt_state = SCG_STOP_NONE;
            default: nxt_state = SCG_STOP_FAST;
          endcase
        end
      end
      SCG_STOP_FAST: begin
        if (irq_wake(wake)) nxt_state = SCG_RUN;
      end
      SCG_STOP_SLOW: begin
        if (irq_wake(wake)) nxt_state = SCG_RUN;
      end
      // A plain interrupt is refused here; nothing runs to service it.
      SCG_STOP_NONE: begin
        if (wake.ext_irq || wake.host_access) nxt_state = SCG_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_ff <= SCG_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Divider producing the clock/256 enable in slow stop. It restarts from
  // zero at each entry, so the first slow enable comes a full period in.
  scgate_div u_div (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .run_in(state_ff == SCG_STOP_SLOW),
    .tick_out(slow_tick)
  );

  // Peripheral enable: full in run and fast stop, divided in slow stop.
  // No-clock stop gives no enable at all, so both timers freeze.
  always_comb begin
    unique case (state_ff)
      SCG_STOP_SLOW: periph_en = slow_tick;
      SCG_STOP_NONE: periph_en = 1'b0;
      default: periph_en = 1'b1;
    endcase
  end

  // Registered clock enables; the processor runs only in run state.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      CPU_CLK_EN_OUT <= 1'b1;
      PERIPH_CLK_EN_OUT <= 1'b1;
    end else begin
      CPU_CLK_EN_OUT <= (state_ff == SCG_RUN);
      PERIPH_CLK_EN_OUT <= periph_en;
    end
  end

  // Registered status: slow flag, state and held selection.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      SLOW_ACTIVE_OUT <= 1'b0;
      STATE_OUT <= SCG_RUN;
      MODE_SEL_OUT <= SCG_SEL_FAST;
    end else begin
      SLOW_ACTIVE_OUT <= (state_ff == SCG_STOP_SLOW);
      STATE_OUT <= state_ff;
      MODE_SEL_OUT <= sel_ff;
    end
  end

  // Frame pulse suppressed for manual conversion with phase A then D.
  // The setting only masks the pulse; the frame counter keeps running.
  assign frame_inhibit = CONV_CTRL_IN[SCG_CONV_MANUAL_BIT] &&
                         FRAME_CTRL_IN[SCG_FRAME_CTRL_STATUS_REG_PHASE_BIT];

  // Frame timer counts peripheral-clock cycles; a slow frame is longer in
  // real time but the count stays valid, so the interval keeps its meaning.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      frame_cnt_ff <= SCG_FRM_ZERO;
      FRAME_START_OUT <= 1'b0;
    end else begin
      FRAME_START_OUT <= 1'b0;
      if (periph_en) begin
        if (cnt_wraps(frame_cnt_ff, FRAME_INTERVAL_IN)) begin
          frame_cnt_ff <= SCG_FRM_ZERO;
          FRAME_START_OUT <= !frame_inhibit;
        end else begin
          frame_cnt_ff <= frame_cnt_ff + SCG_FRM_ONE;
        end
      end
    end
  end

  // Modulo tick timer on the peripheral enable, so its period stretches
  // by 256 in slow stop; frame pulses stretch by the same 256, so
  // neither timer keeps real time in slow stop.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      tick_cnt_ff <= SCG_FRM_ZERO;
      TICK_OUT <= 1'b0;
    end else begin
      TICK_OUT <= 1'b0;
      if (periph_en) begin
        if (cnt_wraps(tick_cnt_ff, TICK_PERIOD_IN)) begin
          tick_cnt_ff <= SCG_FRM_ZERO;
          TICK_OUT <= 1'b1;
        end else begin
          tick_cnt_ff <= tick_cnt_ff + SCG_FRM_ONE;
        end
      end
    end
  end

endmodule // scgate_top
`default_nettype wire

// ===== bench/scgate_assertions.sv
// Purpose: Port checks for the stop mode clock gating block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module scgate_assertions
  import scgate_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic STOP_INSTR_IN,
  input wire logic MODE_SEL_WR_IN,
  input wire logic IRQ_IN,
  input wire logic [scgate_pkg::SCG_CTRL_W-1:0] FRAME_CTRL_IN,
  input wire logic [scgate_pkg::SCG_CTRL_W-1:0] CONV_CTRL_IN,
  input wire logic CPU_CLK_EN_OUT,
  input wire logic PERIPH_CLK_EN_OUT,
  input wire logic SLOW_ACTIVE_OUT,
  input wire scgate_pkg::scgate_state_t STATE_OUT,
  input wire scgate_pkg::scgate_sel_t MODE_SEL_OUT,
  input wire logic FRAME_START_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // Each stop state shows its own pair of outputs: the processor enable with the peripheral enable, or with the slow flag in slow stop.
  a_slow_halts_cpu: assert property (
    STATE_OUT == SCG_STOP_SLOW |-> !CPU_CLK_EN_OUT && SLOW_ACTIVE_OUT)
    else $error("slow stop enables wrong");
  a_none_all_off: assert property (
    STATE_OUT == SCG_STOP_NONE |-> !CPU_CLK_EN_OUT && !PERIPH_CLK_EN_OUT)
    else $error("no-clock stop enables wrong");
  a_fast_periph_on: assert property (
    STATE_OUT == SCG_STOP_FAST |-> !CPU_CLK_EN_OUT && PERIPH_CLK_EN_OUT)
    else $error("fast stop enables wrong");
  // An interrupt in slow stop brings full speed back within the sync delay.
  a_slow_wake_full: assert property (
    $rose(IRQ_IN) && STATE_OUT == SCG_STOP_SLOW |-> ##[3:5]
    (CPU_CLK_EN_OUT && PERIPH_CLK_EN_OUT && !SLOW_ACTIVE_OUT))
    else $error("slow wake too late");
  // Stops happen on the instruction and only then.
  a_stop_enters: assert property (
    STOP_INSTR_IN && STATE_OUT == SCG_RUN && !$past(STOP_INSTR_IN)
    |-> ##2 STATE_OUT != SCG_RUN) else $error("stop not entered");
  a_run_holds: assert property (
    STATE_OUT == SCG_RUN && !$past(STOP_INSTR_IN) |=> STATE_OUT == SCG_RUN)
    else $error("left run without stop");
  a_sof_blocked: assert property (
    CONV_CTRL_IN[SCG_CONV_MANUAL_BIT] && FRAME_CTRL_IN[SCG_FRAME_CTRL_STATUS_REG_PHASE_BIT] &&
    $past(CONV_CTRL_IN[SCG_CONV_MANUAL_BIT] &&
    FRAME_CTRL_IN[SCG_FRAME_CTRL_STATUS_REG_PHASE_BIT]) |-> !FRAME_START_OUT)
    else $error("frame start not blocked");
  // The held setting shows two cycles after its write strobe.
  a_mode_holds: assert property (
    !$past(MODE_SEL_WR_IN, 2) |-> $stable(MODE_SEL_OUT))
    else $error("mode setting drifted");
  // A slow-stop peripheral enable lasts one cycle unless slow stop ends.
  a_slow_periph_pulse: assert property (
    SLOW_ACTIVE_OUT && PERIPH_CLK_EN_OUT |=>
    !PERIPH_CLK_EN_OUT || !SLOW_ACTIVE_OUT)
    else $error("slow peripheral enable too long");
endmodule // scgate_assertions
`default_nettype wire

// ===== bench/scgate_wake_src.sv
// Purpose: Interrupt and host access sources at the far side.
// Assumes: A go bit starts a wake level on that line.
// Notes: Each level is held for nine cycles, then released.
`timescale 1ns/1ps
`default_nettype none
module scgate_wake_src
  import scgate_pkg::*;
(
  input wire logic clk_in,
  input wire logic [2:0] go_in,
  output var scgate_wake_t wake_out
);
  int cnt = 0;
  initial wake_out = '0;
  // Raises the asked lines as levels, like a real pending source.
  always @(posedge clk_in) begin
    if (go_in != 3'h0) begin
      wake_out <= go_in;
      cnt <= 8;
    end else if (cnt > 0) cnt <= cnt - 1;
    else wake_out <= '0;
  end
endmodule // scgate_wake_src
`default_nettype wire

// ===== bench/scgate_top_tb.sv
// Purpose: Self-checking bench for the stop mode clock gating block.
// Assumes: Inputs change 1 ns after each rising edge.
// Notes: State changes are checked against a queue of expectations.
`timescale 1ns/1ps
`default_nettype none
module scgate_top_tb;
  import scgate_pkg::*;
  logic clk = 0, rst = 1, stop = 0, wr = 0, cpu, per, slw, sof, tck;
  scgate_sel_t sel = SCG_SEL_FAST, msel;
  logic [15:0] iv = 16'h0004, tp = 16'h0003;
  logic [7:0] fc = 8'h00, cc = 8'h00;
  logic [2:0] go = 3'h0;
  scgate_wake_t wk;
  scgate_state_t st, q[$];
  int n_errors = 0, comparisons = 0, n;
  scgate_top u_scgate_top (.CLOCK_IN(clk), .RST_IN(rst),
    .STOP_INSTR_IN(stop), .MODE_SEL_IN(sel), .MODE_SEL_WR_IN(wr),
    .IRQ_IN(wk.any_irq), .EXT_IRQ_IN(wk.ext_irq),
    .HOST_ACCESS_IN(wk.host_access), .FRAME_INTERVAL_IN(iv),
    .FRAME_CTRL_IN(fc), .CONV_CTRL_IN(cc), .TICK_PERIOD_IN(tp),
    .CPU_CLK_EN_OUT(cpu), .PERIPH_CLK_EN_OUT(per), .SLOW_ACTIVE_OUT(slw),
    .STATE_OUT(st), .MODE_SEL_OUT(msel), .FRAME_START_OUT(sof),
    .TICK_OUT(tck));
  scgate_wake_src u_scgate_wake_src (.clk_in(clk), .go_in(go),
    .wake_out(wk));
  initial forever #10 clk = ~clk;
  // Counts, compares and ends the run.
  task print_verdict;
    if (q.size() != 0) n_errors++;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp_st(input scgate_state_t g, input scgate_state_t e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t state %0d expected %0d", $time, g, e);
    end
  endtask
  task cmp_v(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t value %0d expected %0d", $time, g, e);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task setm(input scgate_sel_t m);
    wr = 1;
    sel = m;
    step(1);
    wr = 0;
    step(1);
  endtask
  // Measures cycles between two pulses of frame start or tick.
  task gap(input bit t, output int c);
    c = 0;
    do step(1); while ((t ? tck : sof) !== 1'b1);
    do begin step(1); c++; end while ((t ? tck : sof) !== 1'b1);
  endtask
  // Each state change takes the oldest expectation off the queue.
  always @(st) begin
    if (!rst && q.size() == 0) begin
      n_errors++;
      $display("ERROR %0t unexpected state change", $time);
    end else if (!rst) cmp_st(st, q.pop_front());
  end
  initial begin
    #800000;
    n_errors++;
    print_verdict();
  end
  // Walks each stop mode, its timer rates in fast and slow stop, one of its wake sources per pass and the inhibit.
  initial begin
    void'($urandom(51248));
    iv = 16'($urandom_range(5, 2));
    tp = 16'($urandom_range(5, 2));
    step(5);
    rst = 0;
    for (int m = 0; m < 4; m++) begin
      setm(scgate_sel_t'(m > 2 ? 2 : m));
      setm(scgate_sel_t'(2'h3));
      cmp_v(16'(msel), 16'(m > 2 ? 2 : m));
      q.push_back(scgate_state_t'(m > 2 ? 3 : m + 1));
      stop = 1;
      step(1);
      stop = 0;
      step(4);
      if (m < 2) begin
        gap(0, n);
        cmp_v(16'(n), m ? iv * 16'h0100 : iv);
        gap(1, n);
        cmp_v(16'(n), m ? tp * 16'h0100 : tp);
      end else begin
        go = 3'h4;
        step(1);
        go = 3'h0;
        step(20);
        cmp_st(st, SCG_STOP_NONE);
      end
      q.push_back(SCG_RUN);
      go = m < 2 ? 3'h4 : (m == 2 ? 3'h2 : 3'h1);
      step(1);
      go = 3'h0;
      step(20);
      cmp_v(16'(msel), 16'(m > 2 ? 2 : m));
      $display("test %0d done", m);
    end
    fc = 8'h20;
    cc = 8'h01;
    n = 0;
    repeat (40) begin
      step(1);
      if (sof === 1'b1) n++;
    end
    cmp_v(16'(n), 16'h0000);
    fc = 8'h00;
    cc = 8'h00;
    gap(0, n);
    cmp_v(16'(n), iv);
    $display("test inhibit done");
    print_verdict();
  end
endmodule // scgate_top_tb
bind scgate_top scgate_assertions u_scgate_assertions (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .STOP_INSTR_IN(STOP_INSTR_IN),
  .MODE_SEL_WR_IN(MODE_SEL_WR_IN), .IRQ_IN(IRQ_IN),
  .FRAME_CTRL_IN(FRAME_CTRL_IN), .CONV_CTRL_IN(CONV_CTRL_IN),
  .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT), .PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT),
  .SLOW_ACTIVE_OUT(SLOW_ACTIVE_OUT), .STATE_OUT(STATE_OUT),
  .MODE_SEL_OUT(MODE_SEL_OUT), .FRAME_START_OUT(FRAME_START_OUT));
`default_nettype wire
